/* hw/btw_pkg.sv */
// Purpose: Shared constants and types for the base timer, idle wake and watchdog block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Printed offsets 0xB5 and 0xB6 are not multiples of four, so they are indices
package btw_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  BTW_IDX_SERVICE   = 8'hb5;
  localparam logic [7:0]  BTW_IDX_CONTROL   = 8'hb6;
  localparam logic [7:0]  BTW_IDX_STATUS    = 8'hc0;
  localparam logic [7:0]  BTW_IDX_NVCFG     = 8'hc1;
  localparam logic [11:0] BTW_ADDR_SERVICE  = {2'b00, BTW_IDX_SERVICE, 2'b00};
  localparam logic [11:0] BTW_ADDR_CONTROL  = {2'b00, BTW_IDX_CONTROL, 2'b00};
  localparam logic [11:0] BTW_ADDR_STATUS   = {2'b00, BTW_IDX_STATUS, 2'b00};
  localparam logic [11:0] BTW_ADDR_NVCFG    = {2'b00, BTW_IDX_NVCFG, 2'b00};

  // Control register field positions and reset
  localparam int          BTW_BIT_WAKE_IE   = 7;
  localparam int          BTW_BIT_PEND      = 1;
  localparam int          BTW_BIT_TMR_IE    = 0;
  localparam logic [7:0]  BTW_CONTROL_RST   = 8'h00;

  // Status and non-volatile config field positions
  localparam int          BTW_BIT_IDLE      = 0;
  localparam int          BTW_BIT_WDT_RST   = 1;
  localparam int          BTW_BIT_NV_WATCHDOG_RESET_ENABLE_NV   = 0;
  localparam int          BTW_BIT_NV_WPROT  = 1;

  // Counters
  localparam logic [11:0] BTW_BASE_RST      = 12'h000;
  localparam logic [11:0] BTW_BASE_MAX      = 12'hfff;
  localparam logic [3:0]  BTW_WDT_LAST      = 4'hf;
  localparam logic [7:0]  BTW_SERVICE_KEY   = 8'h1b;
  localparam logic [11:0] BTW_RESTART_ADDR  = 12'hc00;
  localparam logic [7:0]  BTW_RESET_HOLD    = 8'h10;

  // Idle state machine
  typedef enum logic [1:0] {
    BTW_RUN  = 2'b01,
    BTW_IDLE = 2'b10
  } btw_mode_e;

  // Watchdog reset request to the system
  typedef struct packed {
    logic        active;
    logic [11:0] restart_addr;
  } btw_sysrst_s;

endpackage

/* hw/btw_timer.sv */
// Purpose: Free-running base timer with overflow flag, idle wake extension and windowed watchdog
// Assumes: pclk is the instruction clock; APB slave, one wait state
// Notes:   Programming-mode pins gate the non-volatile enable; the watchdog reset is a single 16-cycle pulse
//
// Functional notes
// - Base counter is a 12-bit free-running up-counter, prescaler for extensions.
// - Base counter resets to zero, increments every clock without stopping.
// - Base counter value is not visible in the register map.
// - Wrap from all ones sets the overflow pending flag every 4096 clocks.
// - Timer interrupt requested while enable and pending flag are both set.
// - Control: bit 7 wake enable, bit 1 pending, bit 0 timer enable.
// - Writing 1 to pending keeps it, writing 0 clears it.
// - Reset clears the whole control register.
// - One-bit idle extension toggles per overflow; idle overflow every 8192 clocks.
// - Idle overflow while idle resumes execution on the next cycle.
// - Idle overflow flag has no software-visible register bit.
// - Four-bit watchdog extension counts overflows; fifteenth count triggers reset.
// - Watchdog always runs, resets only with non-volatile enable set.
// - Enable set only in programming mode, cleared only there without write protect.
// - Watchdog reset restarts execution at address 0xC00 after reset delay.
// - Writing key 0x1B to service register clears the watchdog count.
// - Service before first count or none by fifteenth causes reset.
// - Watchdog keeps running during idle.
// - Bit 7 is the interrupt enable for the external wakeup function.

`timescale 1ns/1ps
`default_nettype none

module btw_timer
  import btw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_enter,
  input  wire logic        prog_mode,
  output logic             timer_interrupt_request,
  output logic             wakeup_interrupt_enable,
  output logic             core_run,
  output btw_sysrst_s      sysrst
);

  // Register state
  logic [11:0] base_q,  base_d;
  logic        idle_ext_q, idle_ext_d;
  logic [3:0]  wdt_q,   wdt_d;
  logic        wdt_started_q, wdt_started_d;
  logic [7:0]  ctrl_q,  ctrl_d;
  logic        nv_watchdog_reset_enable_nv_q, nv_watchdog_reset_enable_nv_d;
  logic        nv_wprot_q, nv_wprot_d;
  btw_mode_e   mode_q,  mode_d;
  logic [7:0]  hold_q,  hold_d;
  logic        tirq_q,  tirq_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        active_q, active_d;
  logic        run_q,   run_d;

  logic        acc;
  logic        wr;
  logic        overflow;
  logic        idle_ovf;
  logic        svc_wr;
  logic        svc_key;
  logic        bad_svc;
  logic        wdt_expire;
  logic        wdt_fire;
  logic        mapped;

  // Bus decode; one wait state so every answer comes from a flop
  assign acc      = psel && penable && !pready_q;
  assign wr       = acc && pwrite;
  assign mapped   = (paddr == BTW_ADDR_SERVICE) || (paddr == BTW_ADDR_CONTROL) ||
                    (paddr == BTW_ADDR_STATUS)  || (paddr == BTW_ADDR_NVCFG);
  assign overflow = (base_q == BTW_BASE_MAX);
  assign idle_ovf = overflow && idle_ext_q;
  assign svc_wr   = wr && (paddr == BTW_ADDR_SERVICE);
  assign svc_key  = svc_wr && (pwdata[7:0] == BTW_SERVICE_KEY);
  // A key write before the first count is too early
  assign bad_svc  = svc_key && (wdt_q == 4'h0) && !wdt_started_q;
  // Expiry lands on the fifteenth overflow since service or reset, 61440 cycles after reset,
  // so the count is one short of the last code at that edge
  assign wdt_expire = overflow && (wdt_q == (BTW_WDT_LAST - 4'h1));
  assign wdt_fire = nv_watchdog_reset_enable_nv_q && (wdt_expire || bad_svc) && (hold_q == 8'h00);

  // Counters and control register next state
  always_comb begin
    base_d        = base_q + 12'h001;
    idle_ext_d    = overflow ? !idle_ext_q : idle_ext_q;
    wdt_d         = wdt_q;
    wdt_started_d = wdt_started_q;
    if (overflow) begin
      wdt_d         = wdt_q + 4'h1;
      wdt_started_d = 1'b1;
    end
    if (svc_key) begin
      wdt_d         = 4'h0;
      wdt_started_d = overflow;
    end
    ctrl_d = ctrl_q;
    if (wr && (paddr == BTW_ADDR_CONTROL)) begin
      ctrl_d[BTW_BIT_WAKE_IE] = pwdata[BTW_BIT_WAKE_IE];
      ctrl_d[BTW_BIT_TMR_IE]  = pwdata[BTW_BIT_TMR_IE];
      ctrl_d[BTW_BIT_PEND]    = ctrl_q[BTW_BIT_PEND] && pwdata[BTW_BIT_PEND];
    end
    // Set wins over a simultaneous clear so no overflow is lost
    if (overflow) begin
      ctrl_d[BTW_BIT_PEND] = 1'b1;
    end
    ctrl_d[6:2] = 5'b00000;
    tirq_d = ctrl_d[BTW_BIT_TMR_IE] && ctrl_d[BTW_BIT_PEND];
  end

  // Non-volatile watchdog enable, writable only in programming mode
  always_comb begin
    nv_watchdog_reset_enable_nv_d  = nv_watchdog_reset_enable_nv_q;
    nv_wprot_d = nv_wprot_q;
    if (wr && (paddr == BTW_ADDR_NVCFG) && prog_mode) begin
      if (pwdata[BTW_BIT_NV_WATCHDOG_RESET_ENABLE_NV]) begin
        nv_watchdog_reset_enable_nv_d = 1'b1;
      end else if (!nv_wprot_q) begin
        nv_watchdog_reset_enable_nv_d = 1'b0;
      end
      nv_wprot_d = nv_wprot_q || pwdata[BTW_BIT_NV_WPROT];
    end
  end

  // Idle state machine and watchdog reset pulse hold
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      BTW_RUN: begin
        if (idle_enter) begin
          mode_d = BTW_IDLE;
        end
      end
      BTW_IDLE: begin
        if (idle_ovf) begin
          mode_d = BTW_RUN;
        end
      end
      default: begin
        mode_d = BTW_RUN;
      end
    endcase
    hold_d = (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
    if (wdt_fire) begin
      hold_d = BTW_RESET_HOLD;
    end
    // Output flops follow the next state so the pins keep the same timing
    active_d = (hold_d != 8'h00);
    run_d    = (mode_d == BTW_RUN);
  end

  // Read data; the base and idle counts are deliberately absent
  always_comb begin
    prdata_d  = 32'h0000_0000;
    pready_d  = acc;
    pslverr_d = acc && !mapped;
    if (acc && !pwrite) begin
      if (paddr == BTW_ADDR_CONTROL) begin
        prdata_d = {24'h00_0000, ctrl_q};
      end else if (paddr == BTW_ADDR_STATUS) begin
        prdata_d[BTW_BIT_IDLE]    = (mode_q == BTW_IDLE);
        prdata_d[BTW_BIT_WDT_RST] = (hold_q != 8'h00);
      end else if (paddr == BTW_ADDR_NVCFG) begin
        prdata_d[BTW_BIT_NV_WATCHDOG_RESET_ENABLE_NV]  = nv_watchdog_reset_enable_nv_q;
        prdata_d[BTW_BIT_NV_WPROT] = nv_wprot_q;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  // Block state; the watchdog does not clear the non-volatile bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_watchdog_reset_enable_nv_q  <= 1'b0;
      nv_wprot_q <= 1'b0;
      hold_q     <= 8'h00;
      active_q   <= 1'b0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
    end else begin
      nv_watchdog_reset_enable_nv_q  <= nv_watchdog_reset_enable_nv_d;
      nv_wprot_q <= nv_wprot_d;
      hold_q     <= hold_d;
      active_q   <= active_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
    end
  end

  // System-reset domain: watchdog reset acts like any system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q        <= BTW_BASE_RST;
      idle_ext_q    <= 1'b0;
      wdt_q         <= 4'h0;
      wdt_started_q <= 1'b0;
      ctrl_q        <= BTW_CONTROL_RST;
      mode_q        <= BTW_RUN;
      run_q         <= 1'b1;
      tirq_q        <= 1'b0;
    end else if (wdt_fire) begin
      base_q        <= BTW_BASE_RST;
      idle_ext_q    <= 1'b0;
      wdt_q         <= 4'h0;
      wdt_started_q <= 1'b0;
      ctrl_q        <= BTW_CONTROL_RST;
      mode_q        <= BTW_RUN;
      run_q         <= 1'b1;
      tirq_q        <= 1'b0;
    end else begin
      base_q        <= base_d;
      idle_ext_q    <= idle_ext_d;
      wdt_q         <= wdt_d;
      wdt_started_q <= wdt_started_d;
      ctrl_q        <= ctrl_d;
      mode_q        <= mode_d;
      run_q         <= run_d;
      tirq_q        <= tirq_d;
    end
  end

  // Outputs straight from flops
  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign timer_interrupt_request = tirq_q;
  assign wakeup_interrupt_enable = ctrl_q[BTW_BIT_WAKE_IE];
  assign core_run                = run_q;
  // Restart address is a fixed vector; only the active bit is state
  assign sysrst                  = '{active: active_q, restart_addr: BTW_RESTART_ADDR};

  // Assertions
  chk_base_step: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wdt_fire) && $past(presetn) |-> base_q == $past(base_q) + 12'h001)
    else $error("base counter did not advance by one");
  chk_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wdt_fire |=> ctrl_q[BTW_BIT_PEND])
    else $error("overflow did not set pending flag");
  chk_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[BTW_BIT_PEND] && wr && paddr == BTW_ADDR_CONTROL && pwdata[BTW_BIT_PEND] && !wdt_fire
    |=> ctrl_q[BTW_BIT_PEND])
    else $error("write of one cleared pending flag");
  chk_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == BTW_ADDR_CONTROL && !pwdata[BTW_BIT_PEND] && !overflow |=> !ctrl_q[BTW_BIT_PEND])
    else $error("write of zero did not clear pending flag");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[BTW_BIT_TMR_IE] && ctrl_q[BTW_BIT_PEND] |-> timer_interrupt_request)
    else $error("interrupt not requested while pending");
  chk_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == BTW_IDLE && idle_ovf && !wdt_fire |=> core_run)
    else $error("idle did not end on idle overflow");
  chk_wdt_fire: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_expire && nv_watchdog_reset_enable_nv_q && hold_q == 8'h00 |=> sysrst.active ##15 sysrst.active)
    else $error("watchdog expiry did not reset");
  chk_wdt_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !nv_watchdog_reset_enable_nv_q && !$past(sysrst.active) |-> !sysrst.active)
    else $error("reset without watchdog enable");
  chk_svc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    svc_key && !overflow |=> wdt_q == 4'h0)
    else $error("key write did not clear watchdog count");
  chk_svc_other: assert property (@(posedge pclk) disable iff (!presetn)
    svc_wr && !svc_key && !overflow && !wdt_fire |=> wdt_q == $past(wdt_q))
    else $error("non key write changed watchdog count");
  chk_ctrl_unused: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[6:2] == 5'b00000)
    else $error("unused control bits set");


  // A key write before the first count resets at once when enabled
  chk_early_fire: assert property (@(posedge pclk) disable iff (!presetn)
    bad_svc && nv_watchdog_reset_enable_nv_q && hold_q == 8'h00
    |=> sysrst.active)
    else $error("early service did not reset");

  // Each overflow advances the watchdog count unless serviced or reset
  chk_wdt_step: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !svc_key && !wdt_fire
    |=> wdt_q == $past(wdt_q) + 4'h1)
    else $error("watchdog count did not advance on overflow");

  // Idle does not stop the watchdog count
  chk_wdt_idle: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == BTW_IDLE && overflow && !svc_key && !wdt_fire
    |=> wdt_q != $past(wdt_q))
    else $error("watchdog count stalled in idle");

  // Outside programming mode the enable can never move
  chk_nv_locked: assert property (@(posedge pclk) disable iff (!presetn)
    !prog_mode
    |=> $stable(nv_watchdog_reset_enable_nv_q))
    else $error("enable changed outside programming mode");

  // Write protect keeps a set enable set
  chk_nv_protect: assert property (@(posedge pclk) disable iff (!presetn)
    nv_watchdog_reset_enable_nv_q && nv_wprot_q
    |=> nv_watchdog_reset_enable_nv_q)
    else $error("protected enable was cleared");

  // A watchdog reset reinitialises the counter, control and run state
  chk_wdt_reinit: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_fire
    |=> base_q == BTW_BASE_RST && ctrl_q == BTW_CONTROL_RST && core_run)
    else $error("watchdog reset did not reinitialise");

  // The core stays asleep until the idle overflow
  chk_idle_stay: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == BTW_IDLE && !idle_ovf && !wdt_fire
    |=> !core_run)
    else $error("idle left without idle overflow");

  // Software alone can never raise the pending flag
  chk_pend_soft: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[BTW_BIT_PEND] && !overflow
    |=> !ctrl_q[BTW_BIT_PEND])
    else $error("pending flag set without overflow");

  // The idle extension flips on every overflow that does not coincide with a watchdog reset
  chk_idle_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wdt_fire
    |=> idle_ext_q != $past(idle_ext_q))
    else $error("idle extension did not toggle");

  // Wake enable follows the written bit
  chk_wake_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == BTW_ADDR_CONTROL && !wdt_fire
    |=> wakeup_interrupt_enable == $past(pwdata[BTW_BIT_WAKE_IE]))
    else $error("wake enable did not follow write");

  // No request without both enable and pending
  chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(ctrl_q[BTW_BIT_TMR_IE] && ctrl_q[BTW_BIT_PEND])
    |-> !timer_interrupt_request)
    else $error("interrupt requested without pending");

  // Unmapped addresses answer with an error, and the count stays hidden
  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !mapped
    |=> pready && pslverr)
    else $error("unmapped access not refused");

  // Ready is a one-cycle answer; a stuck ready would swallow the next access
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("ready held for more than one cycle");

  cov_overflow: cover property (@(posedge pclk) disable iff (!presetn) overflow);
  cov_idle_wake: cover property (@(posedge pclk) disable iff (!presetn) mode_q == BTW_IDLE ##1 core_run);
  cov_service: cover property (@(posedge pclk) disable iff (!presetn) svc_key && wdt_started_q);
  cov_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn) wdt_fire);

endmodule

`default_nettype wire

/* testbench/base_timer_idle_wake_watchdog_bench.sv */
// Purpose: Self-checking bench for the base timer, idle wake and watchdog block
// Assumes: APB slave with one wait state; watchdog reset clears control but not nv bits
// Notes:   Expiry wait is the full 61440-cycle watchdog window, so the run is ~70k cycles
`timescale 1ns/1ps
`default_nettype none

module base_timer_idle_wake_watchdog_bench;
  import btw_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, idle_enter, prog_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, wake_ie, core_run, er;
  btw_sysrst_s sysrst;
  int          fail_count, tests_run, cyc, t0;

  btw_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_enter(idle_enter), .prog_mode(prog_mode), .timer_interrupt_request(irq),
    .wakeup_interrupt_enable(wake_ie), .core_run(core_run), .sysrst(sysrst)
  );

  // 125 MHz clock and a free cycle count for timing checks
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk(32'(n < 20), 32'h0000_0001);
  endtask

  // Reset values, pending bit not settable by software, unused bits and unmapped access
  task automatic t_regs();
    apb(1'b0, BTW_ADDR_CONTROL, 32'h0000_0000); chk(rd, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000); chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, BTW_ADDR_CONTROL, 32'h0000_00ff);
    apb(1'b0, BTW_ADDR_CONTROL, 32'h0000_0000); chk(rd, 32'h0000_0081);
    chk({31'h0, wake_ie}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // First overflow near 4096 cycles; pending survives a 1 and clears on a 0
  task automatic t_overflow();
    while (irq !== 1'b1 && cyc - t0 < 4200) @(posedge pclk);
    chk(32'(cyc - t0 >= 4090 && cyc - t0 <= 4100), 32'h0000_0001);
    apb(1'b0, BTW_ADDR_CONTROL, 32'h0000_0000); chk(rd, 32'h0000_0083);
    apb(1'b1, BTW_ADDR_CONTROL, 32'h0000_0083);
    apb(1'b0, BTW_ADDR_CONTROL, 32'h0000_0000); chk(rd, 32'h0000_0083);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, BTW_ADDR_CONTROL, 32'h0000_0081);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // Idle is left by the idle overflow within 8192 cycles
  task automatic t_idle();
    int s;
    idle_enter <= 1'b1;
    @(posedge pclk);
    idle_enter <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, core_run}, 32'h0000_0000);
    s = cyc;
    while (core_run !== 1'b1 && cyc - s < 8300) @(posedge pclk);
    chk(32'(cyc - s <= 8192), 32'h0000_0001);
  endtask

  // Non-volatile enable needs programming mode; protect blocks clearing
  task automatic t_nv();
    apb(1'b1, BTW_ADDR_NVCFG, 32'h0000_0001);
    apb(1'b0, BTW_ADDR_NVCFG, 32'h0000_0000); chk(rd, 32'h0000_0000);
    prog_mode <= 1'b1;
    apb(1'b1, BTW_ADDR_NVCFG, 32'h0000_0003);
    apb(1'b1, BTW_ADDR_NVCFG, 32'h0000_0000);
    apb(1'b0, BTW_ADDR_NVCFG, 32'h0000_0000); chk(rd[1:0], 32'h0000_0003);
    prog_mode <= 1'b0;
  endtask

  // Valid service, ignored non-key write, then an early service resets
  task automatic t_early();
    int n;
    apb(1'b1, BTW_ADDR_SERVICE, {24'h0, BTW_SERVICE_KEY});
    apb(1'b1, BTW_ADDR_SERVICE, 32'h0000_001a);
    repeat (3) @(posedge pclk);
    chk({31'h0, sysrst.active}, 32'h0000_0000);
    apb(1'b1, BTW_ADDR_SERVICE, {24'h0, BTW_SERVICE_KEY});
    n = 0;
    while (sysrst.active !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    t0 = cyc;
    chk({31'h0, sysrst.active}, 32'h0000_0001);
    chk({20'h0, sysrst.restart_addr}, 32'h0000_0c00);
    n = 0;
    while (sysrst.active === 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32'h0000_0010);
    apb(1'b0, BTW_ADDR_CONTROL, 32'h0000_0000); chk(rd, 32'h0000_0000);
  endtask

  // With no service the fifteenth watchdog count resets the system
  task automatic t_expire();
    while (sysrst.active !== 1'b1 && cyc - t0 < 62000) @(posedge pclk);
    chk(32'(cyc - t0 >= 61436 && cyc - t0 <= 61444), 32'h0000_0001);
  endtask

  // Hang guard sized above the longest expected run
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; idle_enter = 1'b0; prog_mode = 1'b0;
    fail_count = 0; tests_run = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t0 = cyc;
    chk({31'h0, core_run}, 32'h0000_0001);
    t_regs();
    t_overflow();
    t_idle();
    t_nv();
    t_early();
    t_expire();
    give_verdict();
  end

endmodule
`default_nettype wire
